// ### rtl/sdc_pkg.sv
// Package of encodings, widths and timing for the SDRAM command core
package sdc_pkg;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int NBANK = 8;
  localparam int ROW_W = 14;
  // Address bit positions
  localparam int A_AP = 10;
  localparam int A_BC = 12;
  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_ACT = 3'h3;
  // Burst lengths in beats
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  // Timing at the 40 MHz core clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_RP_NS = 14;
  localparam int T_RFC_NS = 260;
  localparam int RP_CYC_I = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFC_CYC_I = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RP_CYC = 8'(RP_CYC_I);
  localparam logic [7:0] RFC_CYC = 8'(RFC_CYC_I);
  localparam logic [15:0] REF_CNT_RST = 16'h0000;
  localparam logic [7:0] TMR_ZERO = 8'h00;
  localparam logic [7:0] TMR_ONE = 8'h01;
  localparam logic [3:0] BEAT_ZERO = 4'h0;
  localparam logic [3:0] BEAT_ONE = 4'h1;
  typedef enum logic [2:0] {
    SDC_IDLE = 3'b001,
    SDC_SREF = 3'b010,
    SDC_RFSH = 3'b100
  } sdc_mode_t;
endpackage : sdc_pkg

// ### rtl/sdc_core.sv
// Command decode, write burst, precharge, refresh and self refresh core
`timescale 1ns/100ps
// Behaviour
// R1: Write decoded from chip-select and strobes
// R2: A10 high closes row after burst
// R3: A12 picks chop or full burst
// R4: Mask high leaves byte unchanged
// R5: Precharge one bank or all
// R6: Controller waits precharge time first
// R7: Other-bank write allowed during autoclose
// R8: Controller activates idle bank first
// R9: Precharge of idle bank is no-op
// R10: Refresh row from internal counter
// R11: Controller keeps average refresh interval
// R12: Only idle commands during refresh time
// R13: At most eight refreshes postponed
// R14: Postponed count spans self refresh
// R15: Sixteen refreshes per two intervals
// R16: Clock enable high for those commands
// R17: Close all rows before refresh
// R18: Self refresh keeps data clocklessly
// R19: First write waits after reference valid
// R20: Deselect registers no new command
// R21: Controller tracks per-bank timers
module sdc_core
  import sdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic otf_enable,
  input wire logic mode_full_burst,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic [DM_W-1:0] dm,
  output logic [DQ_W-1:0] wr_data,
  output logic [DM_W-1:0] wr_lane_en,
  output logic [COL_W-1:0] wr_col,
  output logic [BA_W-1:0] wr_bank,
  output logic wr_valid,
  output logic [NBANK-1:0] bank_open,
  output logic [NBANK-1:0] bank_precharging,
  output logic refresh_busy,
  output logic [ROW_W-1:0] refresh_row,
  output logic self_refresh
);
  // ==========================================
  // Command decode
  logic cmd_sel;
  logic is_wr, is_pre, is_ref, is_act, is_sre, is_srx;
  logic cke_prev_q, cke_prev_d;
  // R20 deselect blocks decode
  assign cmd_sel = !cs_n && cke && cke_prev_q;
  // R1 write code match
  assign is_wr = cmd_sel && ({ras_n, cas_n, we_n} == CMD_WRITE);
  assign is_pre = cmd_sel && ({ras_n, cas_n, we_n} == CMD_PRE);
  assign is_act = cmd_sel && ({ras_n, cas_n, we_n} == CMD_ACT);
  assign is_ref = cmd_sel && ({ras_n, cas_n, we_n} == CMD_REF);
  assign is_sre = cke_prev_q && !cke && !cs_n && ({ras_n, cas_n, we_n} == CMD_REF);
  assign is_srx = !cke_prev_q && cke;

  // ==========================================
  // Write burst
  logic [3:0] beats_q, beats_d;
  logic [BA_W-1:0] bank_q, bank_d;
  logic [COL_W-1:0] col_q, col_d;
  logic ap_q, ap_d;
  logic [DQ_W-1:0] data_q, data_d;
  logic [DM_W-1:0] lane_q, lane_d;
  logic valid_q, valid_d;
  logic ap_fire;
  always_comb begin
    beats_d = beats_q;
    bank_d = bank_q;
    col_d = col_q;
    ap_d = ap_q;
    valid_d = 1'b0;
    data_d = data_q;
    lane_d = lane_q;
    ap_fire = 1'b0;
    if (beats_q != BEAT_ZERO) begin
      valid_d = 1'b1;
      data_d = dq_in;
      // R4 mask high disables lane
      lane_d = ~dm;
      col_d = col_q + 10'h001;
      beats_d = beats_q - BEAT_ONE;
      // R2 close row on the cycle of the last beat
      ap_fire = ap_q && (beats_q == BEAT_ONE);
    end
    // R7 new write accepted while another bank autocloses
    if (is_wr && (beats_q == BEAT_ZERO || beats_q == BEAT_ONE)) begin
      bank_d = ba;
      col_d = addr[COL_W-1:0] - 10'h001;
      // R2 autoclose flag sampled
      ap_d = addr[A_AP];
      // R3 burst length choice
      if (otf_enable) begin
        beats_d = addr[A_BC] ? BEATS_FULL : BEATS_CHOP;
      end else begin
        beats_d = mode_full_burst ? BEATS_FULL : BEATS_CHOP;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      beats_q <= BEAT_ZERO;
      bank_q <= '0;
      col_q <= '0;
      ap_q <= 1'b0;
      data_q <= '0;
      lane_q <= '0;
      valid_q <= 1'b0;
    end else begin
      beats_q <= beats_d;
      bank_q <= bank_d;
      col_q <= col_d;
      ap_q <= ap_d;
      data_q <= data_d;
      lane_q <= lane_d;
      valid_q <= valid_d;
    end
  end

  // ==========================================
  // Per-bank state
  logic [NBANK-1:0] open_q, open_d, prech_q, prech_d;
  logic [7:0] ptmr_q [NBANK];
  logic [7:0] ptmr_d [NBANK];
  genvar gb;
  generate
    for (gb = 0; gb < NBANK; gb++) begin : g_bank
      logic hit;
      // R5 all banks or addressed bank
      assign hit = is_pre && (addr[A_AP] || ba == BA_W'(gb));
      always_comb begin
        open_d[gb] = open_q[gb];
        prech_d[gb] = prech_q[gb];
        ptmr_d[gb] = ptmr_q[gb];
        if (ptmr_q[gb] != TMR_ZERO) begin
          ptmr_d[gb] = ptmr_q[gb] - TMR_ONE;
          if (ptmr_q[gb] == TMR_ONE) begin
            prech_d[gb] = 1'b0;
          end
        end
        if (is_act && ba == BA_W'(gb)) begin
          open_d[gb] = 1'b1;
        end
        // R9 timer restarts from latest precharge; idle bank stays closed and not precharging
        if (hit || (ap_fire && bank_q == BA_W'(gb))) begin
          ptmr_d[gb] = RP_CYC;
          prech_d[gb] = open_q[gb] || prech_q[gb];
          open_d[gb] = 1'b0;
        end
      end
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          open_q[gb] <= 1'b0;
          prech_q[gb] <= 1'b0;
          ptmr_q[gb] <= TMR_ZERO;
        end else begin
          open_q[gb] <= open_d[gb];
          prech_q[gb] <= prech_d[gb];
          ptmr_q[gb] <= ptmr_d[gb];
        end
      end
    end
  endgenerate

  // ==========================================
  // Refresh and self refresh
  sdc_mode_t mode_q, mode_d;
  logic [7:0] rtmr_q, rtmr_d;
  logic [15:0] rcnt_q, rcnt_d;
  always_comb begin
    mode_d = mode_q;
    rtmr_d = rtmr_q;
    rcnt_d = rcnt_q;
    cke_prev_d = cke;
    unique case (mode_q)
      SDC_IDLE: begin
        if (is_sre) begin
          mode_d = SDC_SREF;
          rcnt_d = rcnt_q + 16'h0001;
        // R10 one refresh from internal counter
        end else if (is_ref) begin
          mode_d = SDC_RFSH;
          rtmr_d = RFC_CYC;
          rcnt_d = rcnt_q + 16'h0001;
        end
      end
      SDC_RFSH: begin
        rtmr_d = rtmr_q - TMR_ONE;
        if (rtmr_q == TMR_ONE) begin
          mode_d = SDC_IDLE;
        end
      end
      // R18 contents held until clock enable returns
      SDC_SREF: begin
        if (is_srx) begin
          mode_d = SDC_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= SDC_IDLE;
      rtmr_q <= TMR_ZERO;
      rcnt_q <= REF_CNT_RST;
      cke_prev_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      rtmr_q <= rtmr_d;
      rcnt_q <= rcnt_d;
      cke_prev_q <= cke_prev_d;
    end
  end

  assign wr_data = data_q;
  assign wr_lane_en = lane_q;
  assign wr_col = col_q;
  assign wr_bank = bank_q;
  assign wr_valid = valid_q;
  assign bank_open = open_q;
  assign bank_precharging = prech_q;
  assign refresh_busy = (mode_q == SDC_RFSH);
  assign refresh_row = rcnt_q[ROW_W-1:0];
  assign self_refresh = (mode_q == SDC_SREF);

  // ==========================================
  // Checks
  AST_DESEL: assert property (@(posedge sys_clk) disable iff (!reset_n) // R20
    cs_n && beats_q == BEAT_ZERO |=> beats_q == BEAT_ZERO)
    else $error("write started on deselect");
  AST_LANE: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    beats_q != BEAT_ZERO |=> wr_lane_en == ~$past(dm)) else $error("mask not applied");
  AST_CHOP: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
    is_wr && otf_enable && !addr[A_BC] && beats_q == BEAT_ZERO |=> beats_q == BEATS_CHOP)
    else $error("chop burst length wrong");
  AST_PREALL: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
    is_pre && addr[A_AP] && !is_act |=> bank_open == '0) else $error("precharge all missed");
  AST_REFT: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
    is_ref && mode_q == SDC_IDLE |=> refresh_busy [*2]) else $error("refresh not held");
  AST_REFCNT: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
    is_ref && mode_q == SDC_IDLE |=> refresh_row == $past(refresh_row) + 14'h0001)
    else $error("refresh row not advanced");
  AST_AP: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
    ap_fire && open_q[bank_q] |=> bank_precharging[$past(bank_q)])
    else $error("autoclose missed");
  AST_SREF: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
    self_refresh && !cke |=> self_refresh) else $error("self refresh left early");
endmodule : sdc_core

// ### tb/sdc_ctl_model.sv
// Controller model driving command, address and data lanes
`timescale 1ns/100ps
module sdc_ctl_model
  import sdc_pkg::*;
(
  input wire logic sys_clk,
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic [DQ_W-1:0] dq_in,
  output logic [DM_W-1:0] dm
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = 3'h7;
    ba = '0;
    addr = '0;
    dq_in = '0;
    dm = '0;
  end
  task automatic issue(input logic [2:0] c, input logic [BA_W-1:0] b,
    input logic [ADDR_W-1:0] a, input logic ck);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    cmd <= c;
    ba <= b;
    addr <= a;
    cke <= ck;
    @(posedge sys_clk);
    cs_n <= 1'b1;
    addr <= ~a;
  endtask : issue
  task automatic stray(input logic [2:0] c);
    @(posedge sys_clk);
    cmd <= c;
    @(posedge sys_clk);
    cmd <= 3'h7;
  endtask : stray
  task automatic set_cke(input logic v);
    @(posedge sys_clk);
    cke <= v;
  endtask : set_cke
  task automatic beat(input logic [DQ_W-1:0] d, input logic [DM_W-1:0] m);
    dq_in <= d;
    dm <= m;
  endtask : beat
endmodule : sdc_ctl_model

// ### tb/sdc_core_tb.sv
// Bench for the SDRAM command core
`timescale 1ns/100ps
module sdc_core_tb;
  import sdc_pkg::*;
  typedef struct packed {
    logic [BA_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic ap, otf, a12, full;
    logic [3:0] n;
  } sdc_row_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic otf_enable = 1'b0;
  logic mode_full_burst = 1'b0;
  logic cke, cs_n, wr_valid, refresh_busy, self_refresh;
  logic [2:0] cmd;
  logic [BA_W-1:0] ba, wr_bank;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_in, wr_data;
  logic [DM_W-1:0] dm, wr_lane_en;
  logic [COL_W-1:0] wr_col;
  logic [NBANK-1:0] bank_open, bank_precharging;
  logic [ROW_W-1:0] refresh_row, row0;
  int err_total = 0;
  int checks_done = 0;
  int k;
  sdc_row_t rows [6] = '{'{3'h1, 10'h010, 1'b0, 1'b1, 1'b0, 1'b0, 4'h4},
    '{3'h2, 10'h020, 1'b0, 1'b1, 1'b1, 1'b0, 4'h8}, '{3'h3, 10'h030, 1'b1, 1'b1, 1'b0, 1'b1, 4'h4},
    '{3'h4, 10'h3F8, 1'b1, 1'b1, 1'b1, 1'b0, 4'h8}, '{3'h5, 10'h040, 1'b0, 1'b0, 1'b1, 1'b0, 4'h4},
    '{3'h6, 10'h050, 1'b1, 1'b0, 1'b0, 1'b1, 4'h8}};
  always #12.5 sys_clk = ~sys_clk;
  sdc_ctl_model ctl_u (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba),
    .addr(addr), .dq_in(dq_in), .dm(dm));
  sdc_core dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
    .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba(ba), .addr(addr),
    .otf_enable(otf_enable), .mode_full_burst(mode_full_burst), .dq_in(dq_in), .dm(dm),
    .wr_data(wr_data), .wr_lane_en(wr_lane_en), .wr_col(wr_col), .wr_bank(wr_bank),
    .wr_valid(wr_valid), .bank_open(bank_open), .bank_precharging(bank_precharging),
    .refresh_busy(refresh_busy), .refresh_row(refresh_row), .self_refresh(self_refresh));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // Counts cycles with write beat (0) or refresh busy (1) high
  task automatic count_hi(input logic sel, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge sys_clk);
      c += int'((sel ? refresh_busy : wr_valid) === 1'b1);
    end
  endtask : count_hi
  task automatic burst(input logic [BA_W-1:0] b, input logic [COL_W-1:0] c, input int n,
    input logic ap);
    logic [DQ_W-1:0] d;
    logic [DM_W-1:0] m;
    for (int i = 0; i < n + 3; i++) begin
      if (i > 0) @(posedge sys_clk);
      ctl_u.beat(i < n ? 16'hA500 + 16'(i) : ~dq_in, i < n ? 2'(i) : ~dm);
      @(negedge sys_clk);
      d = 16'hA500 + 16'(i - 1);
      m = ~2'(i - 1);
      if (i < 1 || i > n) begin
        check(wr_valid, 0);
      end else begin
        check({wr_valid, wr_bank, wr_col, wr_lane_en}, {1'b1, b, c + 10'(i - 1), m});
        check(wr_data & {{8{m[1]}}, {8{m[0]}}}, d & {{8{m[1]}}, {8{m[0]}}});
      end
      if (i == n) begin
        check(bank_precharging, {7'h00, ap} << b);
      end
    end
  endtask : burst
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check({bank_open, wr_valid, refresh_busy, self_refresh}, 0);
    repeat (2) @(posedge sys_clk);
    foreach (rows[r]) begin
      @(posedge sys_clk);
      otf_enable <= rows[r].otf;
      mode_full_burst <= rows[r].full;
      ctl_u.issue(CMD_ACT, rows[r].bank, 14'h0123, 1'b1);
      ctl_u.issue(CMD_WRITE, rows[r].bank, {1'b0, rows[r].a12, 1'b0, rows[r].ap,
        rows[r].col}, 1'b1);
      burst(rows[r].bank, rows[r].col, int'(rows[r].n), rows[r].ap);
      count_hi(1'b0, 4, k);
      check({bank_open[rows[r].bank], bank_precharging}, {!rows[r].ap, 8'h00});
      $display("Write test %0d end", r);
    end
    ctl_u.issue(CMD_PRE, 3'h2, 14'h0000, 1'b1);
    count_hi(1'b0, 4, k);
    check(bank_open, 8'h22);
    ctl_u.issue(CMD_PRE, 3'h2, 14'h0000, 1'b1);
    count_hi(1'b0, 4, k);
    check(bank_open, 8'h22);
    ctl_u.issue(CMD_PRE, 3'h7, 14'h0400, 1'b1);
    count_hi(1'b0, 4, k);
    check(bank_open, 8'h00);
    $display("Precharge test end");
    ctl_u.issue(CMD_REF, 3'h5, 14'h3FFF, 1'b1);
    // only idle cycles until refresh time passes
    count_hi(1'b1, int'(RFC_CYC) + 4, k);
    check(k, RFC_CYC);
    row0 = refresh_row;
    ctl_u.issue(CMD_REF, 3'h0, 14'h0000, 1'b1);
    count_hi(1'b1, int'(RFC_CYC) + 4, k);
    check(refresh_row, row0 + 14'h0001);
    ctl_u.stray(CMD_WRITE);
    count_hi(1'b0, 12, k);
    check(k, 0);
    ctl_u.stray(CMD_REF);
    count_hi(1'b1, 4, k);
    check(k, 0);
    $display("Refresh test end");
    ctl_u.issue(CMD_REF, 3'h0, 14'h0000, 1'b0);
    count_hi(1'b0, 6, k);
    check(self_refresh, 1);
    ctl_u.set_cke(1'b1);
    count_hi(1'b0, 3, k);
    check(self_refresh, 0);
    // first write waits after reference is valid
    count_hi(1'b0, 512, k);
    ctl_u.issue(CMD_ACT, 3'h0, 14'h0001, 1'b1);
    ctl_u.issue(CMD_WRITE, 3'h0, 14'h1008, 1'b1);
    burst(3'h0, 10'h008, 8, 1'b0);
    ctl_u.issue(CMD_ACT, 3'h1, 14'h0002, 1'b1);
    ctl_u.issue(CMD_WRITE, 3'h0, 14'h0410, 1'b1);
    repeat (6) @(posedge sys_clk);
    ctl_u.issue(CMD_WRITE, 3'h1, 14'h0020, 1'b1);
    count_hi(1'b0, 20, k);
    check(k, int'(BEATS_FULL) + 1);
    check(bank_open, 8'h02);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(negedge sys_clk);
    check({bank_open, wr_valid, refresh_busy}, 0);
    $display("Self refresh and reset test end");
    final_report();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    final_report();
  end
endmodule : sdc_core_tb
